// *** core/attr_pkg.sv ***
// Purpose: Shared constants for the storage attribute decoder.
// Assumes: APB register window with 32-bit data, one word per register.
// Notes: The rules that the block keeps follow.
// Function
// - Write-through stores always reach memory.
// - Write-through store hit updates line, stays clean.
// - Inhibited pages access memory, never the cache; cache management ops on them go to the cache only.
// - Cacheable pages may be served from cache.
// - Coherence bit only passed to attribute output.
// - Guarded data access only when required or load-hit.
// - Guarded inhibited access moves only requested bytes.
// - Guarded cacheable access may use whole line.
// - Guarded attribute never restricts instruction fetch.
// - Fetch without execute permission skips memory, flags fault.
// - Byte-order clear means big-endian operands.
// - Byte-order set means little-endian operands.
// - Four user bits always driven on outputs.
// - Transient enable lets second user bit pick region.
// - Override enable lets third user bit steer allocation.
// - Second and third user bits inert unless enabled.
// - First and fourth user bits only passed out.
// - Cache management defined for inhibited and cacheable.
// - Transient on: user bit 0 normal, 1 transient.
// - Override off: global bit decides store-miss allocation.
// - Override on: third user bit 0 allocates.
package attr_pkg;
  // Register byte offsets.
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_STATUS = 12'h004;
  localparam logic [11:0] OFF_MEMCNT = 12'h008;
  // Control register fields.
  localparam int CTRL_NO_ALLOC_BIT = 0;
  localparam int CTRL_TRANSIENT_BIT = 1;
  localparam int CTRL_OVERRIDE_BIT = 2;
  localparam logic [2:0] CTRL_RESET = 3'h0;
  // Status register sticky fields.
  localparam int STAT_ILLEGAL_BIT = 0;
  localparam int STAT_EXEC_FAULT_BIT = 1;
  localparam int STAT_DEFER_BIT = 2;
  // Access kinds on req_kind.
  localparam logic [1:0] KIND_LOAD = 2'h0;
  localparam logic [1:0] KIND_STORE = 2'h1;
  localparam logic [1:0] KIND_FETCH = 2'h2;
  localparam logic [1:0] KIND_CMO = 2'h3;
  // Operand sizes on req_size.
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;
  localparam int LANES = 4;
  localparam int MEMCNT_W = 16;
endpackage

// *** core/attr_lane_if.sv ***
// Purpose: Carries operand, size and byte order to the lane steering module.
// Assumes: Lane 0 is the lowest byte address of the aligned word.
// Notes: Purely combinational bundle.
`timescale 1ns/10ps
interface attr_lane_if;
  logic [1:0] addr_lo;
  logic [1:0] size;
  logic le;
  logic [31:0] operand;
  logic [31:0] lanes;
  logic [3:0] byte_en;
  modport host (output addr_lo, output size, output le, output operand, input lanes, input byte_en);
  modport lane (input addr_lo, input size, input le, input operand, output lanes, output byte_en);
endinterface

// *** core/byte_lane_order.sv ***
// Purpose: Places an operand on byte lanes in big- or little-endian order.
// Assumes: Operand is right-aligned; accesses do not cross a word.
// Notes: Only the requested bytes are enabled, so only a word access enables the whole word.
`timescale 1ns/10ps
module byte_lane_order (
  attr_lane_if.lane lif
);
  // Each lane picks one operand byte, counted from the lowest address.
  for (genvar k = 0; k < attr_pkg::LANES; k++) begin : g_lane
    wire [2:0] nbytes = 3'h1 << lif.size;
    wire [2:0] rel = 3'(k) - {1'b0, lif.addr_lo};
    wire in_range = (3'(k) >= {1'b0, lif.addr_lo}) && (rel < nbytes);
    // Big-endian puts the most significant byte at the lowest address.
    wire [2:0] src = lif.le ? rel : (nbytes - 3'h1 - rel);
    assign lif.byte_en[k] = in_range;
    assign lif.lanes[8*k +: 8] = in_range ? lif.operand[8*src[1:0] +: 8] : 8'h00;
  end
endmodule

// *** core/storage_attribute_decode.sv ***
// Purpose: Decodes page storage attributes into cache and memory actions.
// Assumes: Attributes come from the translation entry matching req_addr.
// Notes: One request per cycle; results appear one cycle later, registered.
//
// Local design decisions: the APB interface to the registers and the register offsets.
`timescale 1ns/10ps
module storage_attribute_decode #(
  parameter int CNT_W = attr_pkg::MEMCNT_W
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic req_valid,
  input wire logic [1:0] req_kind,
  input wire logic [1:0] req_size,
  input wire logic [31:0] req_addr,
  input wire logic [31:0] req_wdata,
  input wire logic req_nonspec,
  input wire logic req_cache_hit,
  input wire logic req_user_mode,
  input wire logic attr_wt,
  input wire logic attr_ci,
  input wire logic attr_coh,
  input wire logic attr_guard,
  input wire logic attr_le,
  input wire logic [3:0] attr_user,
  input wire logic user_exec_perm,
  input wire logic supervisor_exec_perm,
  output logic out_valid,
  output logic [1:0] out_kind,
  output logic [31:0] out_addr,
  output logic [31:0] out_wdata,
  output logic [3:0] out_byte_en,
  output logic out_to_memory,
  output logic out_to_cache,
  output logic out_line_fill,
  output logic out_allocate,
  output logic out_set_dirty,
  output logic out_transient,
  output logic out_defer,
  output logic out_exec_fault,
  output logic xfer_wt,
  output logic xfer_ci,
  output logic xfer_coherent,
  output logic xfer_guarded,
  output logic xfer_le,
  output logic [3:0] xfer_user
);

  ////////////////////////////////////////////////////////////////////////////
  // Control and status state.

  logic global_store_no_alloc_r;
  logic transient_enable_r;
  logic store_alloc_override_en_r;
  logic illegal_seen_r;
  logic exec_fault_seen_r;
  logic defer_seen_r;
  logic [CNT_W-1:0] mem_count_r;

  ////////////////////////////////////////////////////////////////////////////
  // Access classification.

  // Kind decode is shared by the action terms below.
  wire is_load = req_kind == attr_pkg::KIND_LOAD;
  wire is_store = req_kind == attr_pkg::KIND_STORE;
  wire is_fetch = req_kind == attr_pkg::KIND_FETCH;
  wire is_cmo = req_kind == attr_pkg::KIND_CMO;
  wire is_data = is_load | is_store;

  // Execute permission follows the privilege of the fetch.
  wire exec_ok = req_user_mode ? user_exec_perm : supervisor_exec_perm;
  wire fetch_block = is_fetch & ~exec_ok;

  // Guarded pages refuse speculative data access, except loads that hit.
  // Fetches are not data accesses, so the guard never holds them back.
  wire guard_block = attr_guard & is_data & ~req_nonspec & ~(is_load & req_cache_hit);

  wire go = req_valid & ~fetch_block & ~guard_block;

  // The unsupported write-through plus inhibited pair is treated as
  // inhibited, which is the safer of the two readings for I/O space.
  wire illegal_combo = req_valid & attr_wt & attr_ci;
  wire cacheable = ~attr_ci;

  ////////////////////////////////////////////////////////////////////////////
  // Per-page use of the user bits.

  // Only the second and third user bits can reach internal logic.
  wire use_transient = transient_enable_r & attr_user[1];
  wire no_alloc = store_alloc_override_en_r ? attr_user[2] : global_store_no_alloc_r;

  ////////////////////////////////////////////////////////////////////////////
  // Cache and memory actions.

  // Store-miss allocation only makes sense for cacheable stores.
  wire allocate = is_store & cacheable & ~req_cache_hit & ~no_alloc;

  // Cache management ops always look at the cache, whatever the page says,
  // so that a line left behind on an inhibited page is still handled.
  wire to_cache = is_cmo | (cacheable & (~is_store | req_cache_hit | allocate));

  // Inhibited pages go to memory except for cache management ops; write-through stores always do too.
  wire to_memory = ~is_cmo & (attr_ci | ~req_cache_hit | (is_store & attr_wt));

  // Whole-line traffic only for cacheable misses that fill a line.
  wire line_fill = cacheable & ~req_cache_hit & ~is_cmo & (~is_store | allocate);

  // Write-through lines are updated but never marked modified.
  wire set_dirty = is_store & cacheable & ~attr_wt & (req_cache_hit | allocate);

  ////////////////////////////////////////////////////////////////////////////
  // Byte lane steering.

  attr_lane_if lane_bus ();

  assign lane_bus.addr_lo = req_addr[1:0];
  assign lane_bus.size = req_size;
  assign lane_bus.le = attr_le;
  assign lane_bus.operand = req_wdata;

  byte_lane_order u_lane (
    .lif (lane_bus.lane)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Request outputs, held with the attributes of the same request.

  // Everything a request produces lands in the same edge.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      out_valid <= 1'b0;
      out_defer <= 1'b0;
      out_exec_fault <= 1'b0;
    end else begin
      out_valid <= go;
      out_defer <= req_valid & guard_block;
      out_exec_fault <= req_valid & fetch_block;
    end
  end

  // Action flags are qualified by go so a refused request shows nothing.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      out_to_memory <= 1'b0;
      out_to_cache <= 1'b0;
      out_line_fill <= 1'b0;
      out_allocate <= 1'b0;
      out_set_dirty <= 1'b0;
      out_transient <= 1'b0;
    end else begin
      out_to_memory <= go & to_memory;
      out_to_cache <= go & to_cache;
      out_line_fill <= go & line_fill;
      out_allocate <= go & allocate;
      out_set_dirty <= go & set_dirty;
      out_transient <= go & use_transient;
    end
  end

  // Attribute outputs mirror the page for every request, refused or not.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      out_kind <= attr_pkg::KIND_LOAD;
      out_addr <= 32'h0000_0000;
      out_wdata <= 32'h0000_0000;
      out_byte_en <= 4'h0;
      xfer_wt <= 1'b0;
      xfer_ci <= 1'b0;
      xfer_coherent <= 1'b0;
      xfer_guarded <= 1'b0;
      xfer_le <= 1'b0;
      xfer_user <= 4'h0;
    end else if (req_valid) begin
      out_kind <= req_kind;
      out_addr <= req_addr;
      out_wdata <= lane_bus.lanes;
      out_byte_en <= lane_bus.byte_en;
      xfer_wt <= attr_wt;
      xfer_ci <= attr_ci;
      xfer_coherent <= attr_coh;
      xfer_guarded <= attr_guard;
      xfer_le <= attr_le;
      xfer_user <= attr_user;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave.

  // Answer comes one cycle into the access phase, then pready drops.
  wire apb_access = psel & penable;
  wire apb_done = apb_access & pready;
  wire sel_ctrl = paddr == attr_pkg::OFF_CTRL;
  wire sel_status = paddr == attr_pkg::OFF_STATUS;
  wire sel_memcnt = paddr == attr_pkg::OFF_MEMCNT;
  wire mapped = sel_ctrl | sel_status | sel_memcnt;
  wire wr_ctrl = apb_done & pwrite & sel_ctrl;
  wire wr_status = apb_done & pwrite & sel_status;

  // Read data mux; unmapped words read as zero.
  wire [31:0] ctrl_word = {29'h0000_0000, store_alloc_override_en_r, transient_enable_r,
                           global_store_no_alloc_r};
  wire [31:0] status_word = {29'h0000_0000, defer_seen_r, exec_fault_seen_r, illegal_seen_r};
  wire [31:0] rd_word = sel_ctrl ? ctrl_word :
                        sel_status ? status_word :
                        sel_memcnt ? 32'(mem_count_r) : 32'h0000_0000;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= apb_access & ~pready;
      pslverr <= apb_access & ~pready & ~mapped;
      prdata <= (apb_access & ~pready & ~pwrite) ? rd_word : 32'h0000_0000;
    end
  end

  // Control bits change only at the edge that completes the write.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      {store_alloc_override_en_r, transient_enable_r, global_store_no_alloc_r} <= attr_pkg::CTRL_RESET;
    end else if (wr_ctrl) begin
      global_store_no_alloc_r <= pwdata[attr_pkg::CTRL_NO_ALLOC_BIT];
      transient_enable_r <= pwdata[attr_pkg::CTRL_TRANSIENT_BIT];
      store_alloc_override_en_r <= pwdata[attr_pkg::CTRL_OVERRIDE_BIT];
    end
  end

  // Sticky events: writing one clears, but a new event in the same cycle wins.
  wire clr_illegal = wr_status & pwdata[attr_pkg::STAT_ILLEGAL_BIT];
  wire clr_fault = wr_status & pwdata[attr_pkg::STAT_EXEC_FAULT_BIT];
  wire clr_defer = wr_status & pwdata[attr_pkg::STAT_DEFER_BIT];

  always_ff @(posedge clk) begin
    if (!rstn) begin
      illegal_seen_r <= 1'b0;
      exec_fault_seen_r <= 1'b0;
      defer_seen_r <= 1'b0;
    end else begin
      illegal_seen_r <= illegal_combo | (illegal_seen_r & ~clr_illegal);
      exec_fault_seen_r <= (req_valid & fetch_block) | (exec_fault_seen_r & ~clr_fault);
      defer_seen_r <= (req_valid & guard_block) | (defer_seen_r & ~clr_defer);
    end
  end

  // Memory traffic counter wraps; software samples deltas.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      mem_count_r <= '0;
    end else if (go & to_memory) begin
      mem_count_r <= mem_count_r + CNT_W'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  AST_WT_TO_MEMORY: assert property (
    go && is_store && attr_wt && !attr_ci |=> out_valid && out_to_memory)
    else $error("write-through store did not reach memory");

  AST_WT_CLEAN: assert property (
    out_set_dirty |-> !xfer_wt && !xfer_ci && out_kind == attr_pkg::KIND_STORE)
    else $error("dirty set for write-through or inhibited store");

  AST_CI_MEMORY: assert property (
    out_valid && xfer_ci && out_kind != attr_pkg::KIND_CMO |-> out_to_memory && !out_to_cache)
    else $error("inhibited access used the cache");

  AST_COH_PASS: assert property (
    req_valid |=> xfer_coherent == $past(attr_coh))
    else $error("coherence attribute not passed out");

  AST_GUARD_SPEC: assert property (
    req_valid && attr_guard && is_store && !req_nonspec |=> !out_valid && out_defer)
    else $error("speculative guarded store was performed");

  AST_GUARD_CI_EXACT: assert property (
    out_valid && xfer_guarded && xfer_ci |-> !out_line_fill && out_byte_en != 4'h0)
    else $error("guarded inhibited access not byte exact");

  AST_FETCH_NOEXEC: assert property (
    req_valid && is_fetch && !exec_ok |=> out_exec_fault && !out_valid && !out_to_memory)
    else $error("fetch without execute permission went out");

  AST_USER_PASS: assert property (
    req_valid |=> xfer_user == $past(attr_user))
    else $error("user attributes not passed out");

  AST_TRANSIENT: assert property (
    go |=> out_transient == $past(transient_enable_r & attr_user[1]))
    else $error("transient region choice wrong");

  AST_ALLOC_OVERRIDE: assert property (
    go && is_store && !attr_ci && !req_cache_hit && store_alloc_override_en_r && !attr_user[2]
    |=> out_allocate && out_line_fill)
    else $error("override did not allocate store miss");

  AST_BIG_ENDIAN_WORD: assert property (
    req_valid && !attr_le && req_size == attr_pkg::SIZE_WORD && req_addr[1:0] == 2'h0
    |=> out_wdata == {$past(req_wdata[7:0]), $past(req_wdata[15:8]),
                      $past(req_wdata[23:16]), $past(req_wdata[31:24])})
    else $error("big-endian word lanes wrong");

  AST_LITTLE_ENDIAN_WORD: assert property (
    req_valid && attr_le && req_size == attr_pkg::SIZE_WORD && req_addr[1:0] == 2'h0
    |=> out_wdata == $past(req_wdata))
    else $error("little-endian word lanes wrong");

  AST_LOAD_HIT_CACHE: assert property (
    go && is_load && !attr_ci && req_cache_hit |=> out_to_cache && !out_to_memory)
    else $error("cacheable load hit left the cache");

  AST_GUARD_FETCH: assert property (
    req_valid && is_fetch && exec_ok |=> out_valid && !out_defer)
    else $error("guard held back a fetch");

  AST_CMO_CACHE: assert property (
    go && is_cmo |=> out_to_cache && !out_to_memory && !out_line_fill)
    else $error("cache operation not sent to cache");

  AST_USER_INERT: assert property (
    go && !transient_enable_r |=> !out_transient)
    else $error("second user bit acted while disabled");

  AST_GLOBAL_NO_ALLOC: assert property (
    go && is_store && !attr_ci && !req_cache_hit && !store_alloc_override_en_r && global_store_no_alloc_r
    |=> !out_allocate && !out_line_fill && out_to_memory)
    else $error("global no-allocate miss filled a line");

  AST_WT_HIT_CACHE: assert property (
    go && is_store && attr_wt && !attr_ci && req_cache_hit |=> out_to_cache && !out_set_dirty)
    else $error("write-through hit line not clean");

  COV_WT_HIT: cover property (go && is_store && attr_wt && req_cache_hit);
  COV_GUARD_DEFER: cover property (req_valid && guard_block);
  COV_STICKY_SET_CLR: cover property (illegal_combo && clr_illegal);
  COV_CTRL_WRITE: cover property (wr_ctrl ##1 go && allocate);
  COV_TRANSIENT: cover property (go && use_transient);

endmodule

// *** tb/mem_model.sv ***
// Purpose: Passive memory subsystem on the far side of the storage attribute decoder.
// Assumes: The core has no answer path from memory, so the model only listens and stores.
// Notes: Only the low 256 bytes are modelled; higher address bits are ignored.
`timescale 1ns/10ps
module mem_model (
  input wire logic clk,
  input wire logic out_valid,
  input wire logic out_to_memory,
  input wire logic [1:0] out_kind,
  input wire logic [31:0] out_addr,
  input wire logic [31:0] out_wdata,
  input wire logic [3:0] out_byte_en
);
  logic [7:0] mem [0:255];
  int mem_ops = 0;
  ////////////////////////////////////////////////////////////////////////////////
  // Every transfer that reaches memory is counted, so a fetch that must stay off the bus is seen.
  // Store lanes land at their own byte offset, which exposes any byte-order slip.
  always @(posedge clk) begin
    if (out_valid === 1'b1 && out_to_memory === 1'b1) begin
      mem_ops++;
      for (int k = 0; k < attr_pkg::LANES; k++) begin
        if (out_kind === attr_pkg::KIND_STORE && out_byte_en[k] === 1'b1) begin
          mem[{out_addr[7:2], 2'(k)}] <= out_wdata[8*k +: 8];
        end
      end
    end
  end
endmodule

// *** tb/storage_attribute_decode_bench.sv ***
// Purpose: Self-checking bench for the storage attribute decoder.
// Assumes: Inputs change by non-blocking assignment at the rising edge; request outputs are read 1 ns later.
// Notes: The action outputs are packed into act so one compare judges a whole request.
`timescale 1ns/10ps
module storage_attribute_decode_bench;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, req_valid = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, req_addr = '0, req_wdata = '0, prdata, out_addr, out_wdata;
  logic [1:0] req_kind = '0, req_size = '0, out_kind;
  logic req_nonspec = 1'b0, req_cache_hit = 1'b0, req_user_mode = 1'b0;
  logic attr_wt = 1'b0, attr_ci = 1'b0, attr_coh = 1'b0, attr_guard = 1'b0, attr_le = 1'b0;
  logic user_exec_perm = 1'b0, supervisor_exec_perm = 1'b0;
  logic [3:0] attr_user = '0, out_byte_en, xfer_user;
  logic pready, pslverr, out_valid, out_to_memory, out_to_cache, out_line_fill, out_allocate;
  logic out_set_dirty, out_transient, out_defer, out_exec_fault;
  logic xfer_wt, xfer_ci, xfer_coherent, xfer_guarded, xfer_le;
  int err_count = 0;
  int checks = 0;
  logic [31:0] rd, ad, wd;
  logic er;
  logic [1:0] sz;
  // Action flags, most significant first: valid, memory, cache, fill, allocate, dirty, transient, defer, fault.
  wire [8:0] act = {out_valid, out_to_memory, out_to_cache, out_line_fill, out_allocate, out_set_dirty,
    out_transient, out_defer, out_exec_fault};
  always #2 clk = ~clk;
  storage_attribute_decode uut (.clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .req_valid, .req_kind, .req_size, .req_addr, .req_wdata, .req_nonspec, .req_cache_hit,
    .req_user_mode, .attr_wt, .attr_ci, .attr_coh, .attr_guard, .attr_le, .attr_user, .user_exec_perm,
    .supervisor_exec_perm, .out_valid, .out_kind, .out_addr, .out_wdata, .out_byte_en, .out_to_memory,
    .out_to_cache, .out_line_fill, .out_allocate, .out_set_dirty, .out_transient, .out_defer,
    .out_exec_fault, .xfer_wt, .xfer_ci, .xfer_coherent, .xfer_guarded, .xfer_le, .xfer_user);
  mem_model mdl (.clk, .out_valid, .out_to_memory, .out_kind, .out_addr, .out_wdata, .out_byte_en);
  ////////////////////////////////////////////////////////////////////////////////
  // Shared comparison, bus cycle and request tasks.
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // The request is held until pready is seen high; the wait is bounded so a dead slave is reported.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Sampled at the edge itself, so the answer is taken at the very edge that completes the transfer.
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      chk("pready", 32'h0000_0001, 32'h0000_0000);
      tally_and_finish();
    end
  endtask
  // Attribute vector is wt, ci, coh, guard, le; mode vector is uperm, sperm, nonspec, hit, user.
  task automatic req(input logic [1:0] k, input logic [4:0] at, input logic [3:0] u, input logic [4:0] m,
    input logic [8:0] e, input string nm);
    @(posedge clk);
    req_valid <= 1'b1;
    req_kind <= k;
    req_size <= sz;
    req_addr <= ad;
    req_wdata <= wd;
    {attr_wt, attr_ci, attr_coh, attr_guard, attr_le} <= at;
    attr_user <= u;
    {user_exec_perm, supervisor_exec_perm, req_nonspec, req_cache_hit, req_user_mode} <= m;
    @(posedge clk);
    req_valid <= 1'b0;
    #1;
    chk(nm, 32'(e), 32'(act));
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios.
  task automatic t_regs();
    apb(1'b0, attr_pkg::OFF_CTRL, '0);
    chk("ctrl reset", 32'h0000_0000, rd);
    apb(1'b1, attr_pkg::OFF_CTRL, 32'hffff_ffff);
    apb(1'b0, attr_pkg::OFF_CTRL, '0);
    chk("ctrl rw", 32'h0000_0007, rd);
    apb(1'b1, attr_pkg::OFF_CTRL, '0);
    apb(1'b0, 12'h00c, '0);
    chk("unmapped err", 32'h0000_0001, 32'(er));
    chk("unmapped data", 32'h0000_0000, rd);
  endtask
  // Inhibited targets are never presented as cache hits, except for cache operations.
  task automatic t_wt_endian();
    req(attr_pkg::KIND_STORE, 5'h10, 4'h0, 5'h1a, 9'h1c0, "wt store hit");
    chk("wt attr", 32'h0000_0001, 32'(xfer_wt));
    chk("be lanes", 32'h4433_2211, out_wdata);
    // The memory model stores at the edge after the answer, so one edge passes first.
    @(posedge clk);
    #1;
    chk("be mem", 32'h0000_0011, 32'(mdl.mem[8'h40]));
    ad = 32'h0000_0044;
    req(attr_pkg::KIND_STORE, 5'h11, 4'h0, 5'h1a, 9'h1c0, "le store");
    chk("le lanes", 32'h1122_3344, out_wdata);
    @(posedge clk);
    #1;
    chk("le mem", 32'h0000_0044, 32'(mdl.mem[8'h44]));
    chk("le attr", 32'h0000_0001, 32'(xfer_le));
    sz = attr_pkg::SIZE_HALF;
    ad = 32'h0000_004a;
    wd = 32'h0000_aabb;
    req(attr_pkg::KIND_STORE, 5'h10, 4'h0, 5'h1a, 9'h1c0, "half store");
    chk("half enables", 32'h0000_000c, 32'(out_byte_en));
    chk("half lanes", 32'h0000_bbaa, 32'(out_wdata[31:16]));
    sz = attr_pkg::SIZE_WORD;
    ad = 32'h0000_0040;
  endtask
  task automatic t_inhibit();
    req(attr_pkg::KIND_LOAD, 5'h08, 4'h0, 5'h18, 9'h180, "ci load");
    req(attr_pkg::KIND_STORE, 5'h08, 4'h0, 5'h18, 9'h180, "ci store");
    req(attr_pkg::KIND_FETCH, 5'h08, 4'h0, 5'h18, 9'h180, "ci fetch");
    req(attr_pkg::KIND_LOAD, 5'h00, 4'h0, 5'h18, 9'h1e0, "load miss");
    req(attr_pkg::KIND_LOAD, 5'h00, 4'h0, 5'h1a, 9'h140, "load hit");
    req(attr_pkg::KIND_CMO, 5'h08, 4'h0, 5'h1a, 9'h140, "cmo ci hit");
    req(attr_pkg::KIND_CMO, 5'h02, 4'h0, 5'h18, 9'h140, "cmo guarded");
  endtask
  task automatic t_guard();
    req(attr_pkg::KIND_LOAD, 5'h02, 4'h0, 5'h18, 9'h002, "guard spec miss");
    req(attr_pkg::KIND_STORE, 5'h02, 4'h0, 5'h1a, 9'h002, "guard spec store");
    req(attr_pkg::KIND_LOAD, 5'h02, 4'h0, 5'h1a, 9'h140, "guard load hit");
    req(attr_pkg::KIND_LOAD, 5'h02, 4'h0, 5'h1c, 9'h1e0, "guard line");
    req(attr_pkg::KIND_FETCH, 5'h02, 4'h0, 5'h18, 9'h1e0, "guard fetch");
    sz = attr_pkg::SIZE_BYTE;
    ad = 32'h0000_0053;
    wd = 32'h0000_005a;
    req(attr_pkg::KIND_STORE, 5'h0a, 4'h0, 5'h1c, 9'h180, "guard ci byte");
    chk("byte enables", 32'h0000_0008, 32'(out_byte_en));
    chk("guard ci attr", 32'h0000_0003, 32'({xfer_guarded, xfer_ci}));
    @(posedge clk);
    #1;
    chk("byte mem", 32'h0000_005a, 32'(mdl.mem[8'h53]));
    sz = attr_pkg::SIZE_WORD;
    ad = 32'h0000_0040;
  endtask
  task automatic t_exec();
    int n0;
    n0 = mdl.mem_ops;
    req(attr_pkg::KIND_FETCH, 5'h00, 4'h0, 5'h09, 9'h001, "user no exec");
    req(attr_pkg::KIND_FETCH, 5'h00, 4'h0, 5'h10, 9'h001, "sup no exec");
    @(posedge clk);
    #1;
    chk("no fetch bus", 32'(n0), 32'(mdl.mem_ops));
    req(attr_pkg::KIND_FETCH, 5'h00, 4'h0, 5'h08, 9'h1e0, "sup exec");
    req(attr_pkg::KIND_FETCH, 5'h00, 4'h0, 5'h11, 9'h1e0, "user exec");
  endtask
  task automatic t_user();
    req(attr_pkg::KIND_LOAD, 5'h04, 4'h9, 5'h1a, 9'h140, "coh u0 u3");
    chk("coh attr", 32'h0000_0001, 32'(xfer_coherent));
    chk("user attr", 32'h0000_0009, 32'(xfer_user));
    req(attr_pkg::KIND_STORE, 5'h00, 4'h6, 5'h18, 9'h1f8, "u1 u2 inert");
    chk("user attr 2", 32'h0000_0006, 32'(xfer_user));
    apb(1'b1, attr_pkg::OFF_CTRL, 32'h0000_0002);
    req(attr_pkg::KIND_LOAD, 5'h00, 4'h2, 5'h1a, 9'h144, "transient");
    req(attr_pkg::KIND_LOAD, 5'h00, 4'hd, 5'h1a, 9'h140, "normal");
  endtask
  task automatic t_alloc();
    apb(1'b1, attr_pkg::OFF_CTRL, 32'h0000_0001);
    req(attr_pkg::KIND_STORE, 5'h00, 4'h0, 5'h18, 9'h180, "global no alloc");
    apb(1'b1, attr_pkg::OFF_CTRL, 32'h0000_0005);
    req(attr_pkg::KIND_STORE, 5'h00, 4'h0, 5'h18, 9'h1f8, "override alloc");
    apb(1'b1, attr_pkg::OFF_CTRL, 32'h0000_0004);
    req(attr_pkg::KIND_STORE, 5'h00, 4'h4, 5'h18, 9'h180, "override no alloc");
    apb(1'b1, attr_pkg::OFF_CTRL, 32'h0000_0000);
  endtask
  // The write-through plus inhibited store is a software fault on purpose, to set the status flag.
  task automatic t_status();
    logic [31:0] m0;
    apb(1'b0, attr_pkg::OFF_MEMCNT, '0);
    m0 = rd;
    req(attr_pkg::KIND_STORE, 5'h18, 4'h0, 5'h18, 9'h180, "wt ci store");
    repeat (2) @(posedge clk);
    #1;
    chk("held addr", ad, out_addr);
    chk("held kind", 32'(attr_pkg::KIND_STORE), 32'(out_kind));
    chk("pulses end", 32'h0000_0000, 32'(act));
    apb(1'b1, attr_pkg::OFF_MEMCNT, 32'h0000_1234);
    apb(1'b0, attr_pkg::OFF_MEMCNT, '0);
    chk("memcnt", m0 + 32'h0000_0001, rd);
    apb(1'b0, attr_pkg::OFF_STATUS, '0);
    chk("status", 32'h0000_0007, rd);
    apb(1'b1, attr_pkg::OFF_STATUS, 32'h0000_0007);
    apb(1'b0, attr_pkg::OFF_STATUS, '0);
    chk("status clear", 32'h0000_0000, rd);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Verdict and run control.
  task automatic tally_and_finish();
    if (err_count == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    #20000;
    err_count++;
    tally_and_finish();
  end
  initial begin
    sz = attr_pkg::SIZE_WORD;
    ad = 32'h0000_0040;
    wd = 32'h1122_3344;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    #1;
    chk("reset act", 32'h0000_0000, 32'(act));
    t_regs();
    t_wt_endian();
    t_inhibit();
    t_guard();
    t_exec();
    t_user();
    t_alloc();
    t_status();
    tally_and_finish();
  end
endmodule
